// ---- core/sdram_controller_core.sv ----
// SDRAM controller: memory slave port to single-data-rate SDRAM pins
//
// Behaviour
// - Data width 8/16/32/64, multiple chip selects
// - All options fixed as build parameters
// - Flat linear address space, commands hidden
// - Memory only, no configuration registers
// - Wait states stall master until ready
// - Pipelined reads, one word per cycle
// - Refresh may pause data return
// - Clock enable always high, no power-down
// - Shared pins driven only while bridge granted
// - One open row in one bank
// - Keep bridge while same row continues
// - Close row when traffic stops or refresh
// - Column latency 1, 2 or 3 cycles
// - Chip selects 1/2/4/8, banks 2/4
// - Row 11-14 bits, column 8 to row-1
`include "sdram_defines.svh"

module sdram_controller_core
    import sdram_pkg::*;
#(
    parameter int DATA_W   = 32,
    parameter int NUM_CS   = 1,
    parameter int NUM_BANK = 4,
    parameter int ROW_W    = 12,
    parameter int COL_W    = 8,
    parameter int CAS_LAT  = 3,
    parameter bit SHARE_PINS = 1'b0,
    parameter int T_REFI_CYC = `CYC_DOWN(`T_REFI_NS),
    parameter int T_INIT_CYC = `CYC_UP(`T_INIT_NS),
    localparam int BA_W  = $clog2(NUM_BANK),
    localparam int CS_W  = (NUM_CS > 1) ? $clog2(NUM_CS) : 1,
    localparam int CSB_W = (NUM_CS > 1) ? $clog2(NUM_CS) : 0,
    localparam int ADR_W = CSB_W + BA_W + ROW_W + COL_W,
    localparam int BE_W  = DATA_W / 8
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // Memory slave port
    input  wire logic [ADR_W-1:0]  s_address,
    input  wire logic              s_read,
    input  wire logic              s_write,
    input  wire logic [DATA_W-1:0] s_writedata,
    input  wire logic [BE_W-1:0]   s_byteenable,
    output logic                   s_waitrequest,
    output logic [DATA_W-1:0]      s_readdata,
    output logic                   s_readdatavalid,
    // Shared pin bridge arbitration
    output logic                   bridge_req,
    input  wire logic              bridge_grant,
    // SDRAM command pins
    output logic                   sd_cke,
    output logic [NUM_CS-1:0]      sd_cs_n,
    output logic                   sd_ras_n,
    output logic                   sd_cas_n,
    output logic                   sd_we_n,
    output logic [BA_W-1:0]        sd_ba,
    output logic [ROW_W-1:0]       sd_addr,
    output logic [ROW_W-1:0]       sd_addr_oe,
    // SDRAM data pins
    input  wire logic [DATA_W-1:0] sd_dq_in,
    output logic [DATA_W-1:0]      sd_dq_out,
    output logic                   sd_dq_oe,
    output logic [BE_W-1:0]        sd_dqm,
    output logic                   sd_dqm_oe
);
    // ------------------------------------------------------------
    // Build-time checks and derived counts
    // ------------------------------------------------------------
    initial
    begin
        if (!(DATA_W inside {8, 16, 32, 64}) || !(NUM_CS inside {1, 2, 4, 8}) ||
            !(NUM_BANK inside {2, 4}) || ROW_W < 11 || ROW_W > 14 ||
            COL_W < 8 || COL_W >= ROW_W || CAS_LAT < 1 || CAS_LAT > 3)
            $error("unsupported sdram configuration");
    end

    localparam int RCD_C = `CYC_UP(`T_RCD_NS) < 1 ? 1 : `CYC_UP(`T_RCD_NS);
    localparam int RP_C  = `CYC_UP(`T_RP_NS) < 1 ? 1 : `CYC_UP(`T_RP_NS);
    localparam int RFC_C = `CYC_UP(`T_RFC_NS) < 1 ? 1 : `CYC_UP(`T_RFC_NS);
    localparam int TMR_W = $clog2(T_INIT_CYC + 1) + 1;
    localparam int RFI_W = $clog2(T_REFI_CYC + 1) + 1;
    localparam int CMD_W = 1 + ADR_W + DATA_W + BE_W;
    localparam int RP_W  = CSB_W + BA_W + ROW_W;

    // ------------------------------------------------------------
    // Request FIFO: address, direction, data and mask
    // ------------------------------------------------------------
    wdata_if #(.W(CMD_W)) req_in ();
    wdata_if #(.W(CMD_W)) req_out ();

    sdram_fifo #(.WIDTH(CMD_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .mclk  (mclk),
        .rst   (rst),
        .in_s  (req_in),
        .out_s (req_out)
    );

    ctrl_state_e state;
    ctrl_state_e ret_state;
    logic [TMR_W-1:0]  timer;
    logic [RFI_W-1:0]  ref_cnt;
    logic              ref_due;
    logic [1:0]        init_refs;
    logic              row_open;
    logic [RP_W-1:0]   open_row;
    logic [3:0]        cmd;
    logic [CS_W-1:0]   cmd_cs;
    logic [CAS_LAT:0]  rd_pipe;
    logic              rd_valid_q;

    // stall only while the request queue is full or init runs
    wire init_busy   = (state == st_wait) &&
                       (ret_state == st_init_ref || ret_state == st_init_mode);
    wire ready_state = (state != st_init_wait) && (state != st_init_pre) &&
                       (state != st_init_ref) && (state != st_init_mode) && !init_busy;
    assign s_waitrequest = !(req_in.ready && ready_state);
    assign req_in.valid  = (s_read || s_write) && !s_waitrequest;
    assign req_in.data   = {s_write, s_address, s_writedata, s_byteenable};

    // ------------------------------------------------------------
    // Decode of the head request (flat address: cs|row|bank|col)
    // ------------------------------------------------------------
    wire              head_wr   = req_out.data[CMD_W-1];
    wire [ADR_W-1:0]  head_adr  = req_out.data[CMD_W-2 -: ADR_W];
    wire [DATA_W-1:0] head_wd   = req_out.data[BE_W +: DATA_W];
    wire [BE_W-1:0]   head_be   = req_out.data[BE_W-1:0];
    wire [COL_W-1:0]  head_col  = head_adr[COL_W-1:0];
    wire [BA_W-1:0]   head_ba   = head_adr[COL_W +: BA_W];
    wire [RP_W-1:0]   head_rowp = head_adr[ADR_W-1 -: RP_W];
    wire [ROW_W-1:0]  head_row  = head_rowp[BA_W +: ROW_W];
    wire [CS_W-1:0]   head_cs;
    if (NUM_CS > 1)
    begin : g_cs
        assign head_cs = head_adr[ADR_W-1 -: CS_W];
    end
    else
    begin : g_cs1
        assign head_cs = '0;
    end
    // same row/bank/chip hits the open row
    wire row_hit   = row_open && (open_row == head_rowp);
    wire pin_owned = !SHARE_PINS || bridge_grant;
    wire timer_done = (timer == '0);
    // A write waits until read data in flight has left the data lines
    wire issue_col = (state == st_open) && req_out.valid && row_hit && pin_owned &&
                     !ref_due && !(head_wr && rd_pipe != '0);
    assign req_out.ready = issue_col;

    // ------------------------------------------------------------
    // Refresh interval counter
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            ref_cnt <= '0;
        else if (!ready_state || state == st_refresh)
            ref_cnt <= RFI_W'(T_REFI_CYC);
        else if (ref_cnt != '0)
            ref_cnt <= ref_cnt - 1'b1;
    end
    assign ref_due = ready_state && (ref_cnt == '0);

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state     <= st_init_wait;
            ret_state <= st_idle;
            timer     <= TMR_W'(T_INIT_CYC);
            init_refs <= '0;
            row_open  <= 1'b0;
            open_row  <= '0;
            cmd       <= `CMD_NOP;
            cmd_cs    <= '0;
        end
        else
        begin
            cmd <= `CMD_NOP;
            if (!timer_done)
                timer <= timer - 1'b1;
            unique case (state)
                // power-up wait, precharge all, refreshes, mode load
                st_init_wait:
                    if (timer_done && pin_owned)
                    begin
                        cmd   <= `CMD_PRECHARGE;
                        state <= st_wait;
                        ret_state <= st_init_ref;
                        timer <= TMR_W'(RP_C - 1);
                    end
                st_init_pre:
                    state <= st_init_ref;
                st_init_ref:
                    if (init_refs == 2'(`INIT_REFRESHES) && pin_owned)
                    begin
                        cmd   <= `CMD_LOADMODE;
                        state <= st_wait;
                        ret_state <= st_init_mode;
                        timer <= TMR_W'(`T_MRD_CYC - 1);
                    end
                    else if (init_refs != 2'(`INIT_REFRESHES))
                    begin
                        cmd   <= `CMD_REFRESH;
                        init_refs <= init_refs + 1'b1;
                        state <= st_wait;
                        ret_state <= st_init_ref;
                        timer <= TMR_W'(RFC_C - 1);
                    end
                st_init_mode:
                    state <= st_idle;
                st_idle:
                    if (ref_due)
                        state <= st_refresh;
                    else if (req_out.valid && pin_owned)
                    begin
                        cmd      <= `CMD_ACTIVE;
                        cmd_cs   <= head_cs;
                        open_row <= head_rowp;
                        row_open <= 1'b1;
                        state    <= st_wait;
                        ret_state <= st_open;
                        timer    <= TMR_W'(RCD_C - 1);
                    end
                st_open:
                    // close when traffic breaks, misses or refresh is due
                    if (issue_col)
                        cmd <= head_wr ? `CMD_WRITE : `CMD_READ;
                    else if (rd_pipe == '0)
                        state <= st_precharge;
                st_precharge:
                begin
                    cmd      <= `CMD_PRECHARGE;
                    row_open <= 1'b0;
                    state    <= st_wait;
                    ret_state <= st_idle;
                    timer    <= TMR_W'(RP_C - 1);
                end
                st_refresh:
                begin
                    cmd   <= `CMD_REFRESH;
                    state <= st_wait;
                    ret_state <= st_idle;
                    timer <= TMR_W'(RFC_C - 1);
                end
                st_wait:
                    if (timer_done)
                        state <= ret_state;
                default:
                    state <= st_idle;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin registers
    // ------------------------------------------------------------
    logic [BA_W-1:0]   ba_q;
    logic [ROW_W-1:0]  addr_q;
    logic [DATA_W-1:0] dq_q;
    logic [BE_W-1:0]   dqm_q;
    logic              dq_oe_q;

    wire [ROW_W-1:0] col_addr = ROW_W'(head_col);
    wire [ROW_W-1:0] mode_word = ROW_W'({3'(CAS_LAT), 1'b0, `MODE_BURST1});
    wire [ROW_W-1:0] all_banks = ROW_W'(1) << `A10_BIT;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ba_q      <= '0;
            addr_q    <= '0;
            dq_q      <= '0;
            dqm_q     <= '1;
            dq_oe_q   <= 1'b0;
        end
        else
        begin
            dq_oe_q   <= issue_col && head_wr;
            dq_q      <= head_wd;
            dqm_q     <= issue_col ? ~head_be : '0;
            if (state == st_idle)
            begin
                ba_q   <= head_ba;
                addr_q <= head_row;
            end
            else if (issue_col)
            begin
                ba_q   <= head_ba;
                addr_q <= col_addr;
            end
            else if (state == st_init_wait || state == st_precharge)
                addr_q <= all_banks;
            else if (state == st_init_ref)
                addr_q <= mode_word;
        end
    end

    // clock enable never drops
    assign sd_cke     = 1'b1;
    assign sd_ras_n   = cmd[2];
    assign sd_cas_n   = cmd[1];
    assign sd_we_n    = cmd[0];
    assign sd_ba      = ba_q;
    assign sd_addr    = addr_q;
    // enables follow the grant itself, so a lost grant frees the pins at once
    assign sd_addr_oe = {ROW_W{pin_owned}};
    assign sd_dq_out  = dq_q;
    assign sd_dq_oe   = dq_oe_q && pin_owned;
    assign sd_dqm     = dqm_q;
    assign sd_dqm_oe  = pin_owned;
    // hold the bridge while a row is open or init needs the pins
    assign bridge_req = SHARE_PINS && (row_open || req_out.valid || !ready_state);

    for (genvar i = 0; i < NUM_CS; i++)
    begin : g_csn
        // one chip select per chip, all selected for init/refresh
        assign sd_cs_n[i] = cmd[3] ||
            !(cmd == `CMD_REFRESH || cmd == `CMD_LOADMODE ||
              (cmd == `CMD_PRECHARGE && state != st_idle) || cmd_cs == CS_W'(i));
    end

    // ------------------------------------------------------------
    // Read return after the column latency
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rd_pipe    <= '0;
            rd_valid_q <= 1'b0;
            s_readdata <= '0;
        end
        else
        begin
            rd_pipe    <= {rd_pipe[CAS_LAT-1:0], issue_col && !head_wr};
            rd_valid_q <= rd_pipe[CAS_LAT];
            s_readdata <= sd_dq_in;
        end
    end
    assign s_readdatavalid = rd_valid_q;
endmodule

// ---- core/sdram_defines.svh ----
// Timing, command and layout constants for the SDRAM controller
`ifndef SDRAM_DEFINES_SVH
`define SDRAM_DEFINES_SVH

// ----------------------------------------------------------------
// Command encodings {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------------------------------
`define CMD_NOP       4'h7
`define CMD_ACTIVE    4'h3
`define CMD_READ      4'h5
`define CMD_WRITE     4'h4
`define CMD_PRECHARGE 4'h2
`define CMD_REFRESH   4'h1
`define CMD_LOADMODE  4'h0

// ----------------------------------------------------------------
// Timing figures in ns (T_MRD_CYC in cycles) and the clock period
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define T_RCD_NS      20
`define T_RP_NS       20
`define T_RFC_NS      70
`define T_MRD_CYC     2
`define T_REFI_NS     15625
`define T_INIT_NS     100000
`define INIT_REFRESHES 2

// Least times round up, longest times round down
`define CYC_UP(ns)   (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_DOWN(ns) ((ns) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Misc fields
// ----------------------------------------------------------------
`define A10_BIT       10
`define MODE_BURST1   3'h0
`define FIFO_DEPTH    8

`endif

// ---- core/sdram_fifo.sv ----
// Parameterised valid/ready FIFO for the request path
module sdram_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Fill side
    wdata_if.snk     in_s,
    // Drain side
    wdata_if.src     out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      fill;
    wire              do_push;
    wire              do_pop;

    assign fill        = wr_ptr - rd_ptr;
    assign in_s.ready  = (fill != (AW+1)'(DEPTH));
    assign out_s.valid = (fill != '0);
    assign out_s.data  = mem[rd_ptr[AW-1:0]];
    assign do_push     = in_s.valid && in_s.ready;
    assign do_pop      = out_s.valid && out_s.ready;

    always_ff @(posedge mclk)
    begin
        if (do_push)
            mem[wr_ptr[AW-1:0]] <= in_s.data;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_pop)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

// ---- core/sdram_pkg.sv ----
// Types shared by the SDRAM controller modules
package sdram_pkg;
    typedef enum logic [3:0] {
        st_init_wait,
        st_init_pre,
        st_init_ref,
        st_init_mode,
        st_idle,
        st_active,
        st_open,
        st_precharge,
        st_refresh,
        st_wait
    } ctrl_state_e;
endpackage

// ---- core/wdata_if.sv ----
// Stream carrier between the controller and its request FIFO
interface wdata_if #(parameter int W = 32);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- dv/sdram_chip_model.sv ----
// Behavioural SDRAM chip seen through the controller pins
`include "sdram_defines.svh"

module sdram_chip_model #(
    parameter int CL = 3
) (
    // Clock and command
    input  wire logic        mclk,
    input  wire logic [3:0]  cmd,
    input  wire logic [1:0]  ba,
    input  wire logic [11:0] addr,
    // Data
    input  wire logic [31:0] dq_out,
    input  wire logic        dq_oe,
    input  wire logic [3:0]  dqm,
    output logic [31:0]      dq_in,
    // Refresh commands seen
    output int               ref_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [logic [21:0]];
    logic [11:0] open_row [4];
    logic [31:0] pd [CL];
    logic [CL-1:0] pv = '0;
    logic [31:0] last = 32'h0;
    logic [31:0] w;
    wire logic [21:0] key = {ba, open_row[ba], addr[7:0]};

    initial ref_cnt = 0;
    // A released bus shows the inverse of its last level, never a stale copy
    assign dq_in = dq_oe ? dq_out : (pv[0] ? pd[0] : ~last);

    always @(posedge mclk)
    begin
        last <= dq_in;
        w = mem.exists(key) ? mem[key] : 32'h0;
        for (int i = 0; i < CL - 1; i++)
            pd[i] <= pd[i + 1];
        pd[CL-1] <= w;
        pv <= (pv >> 1) | ((cmd == `CMD_READ) << (CL - 1));
        if (cmd == `CMD_ACTIVE)
            open_row[ba] <= addr;
        if (cmd == `CMD_REFRESH)
            ref_cnt <= ref_cnt + 1;
        if (cmd == `CMD_WRITE)
        begin
            for (int b = 0; b < 4; b++)
                if (!dqm[b])
                    w[8*b +: 8] = dq_out[8*b +: 8];
            mem[key] = w;
        end
    end
endmodule

// ---- dv/sdram_controller_core_properties.sv ----
// Port-level assertions for the SDRAM controller core
`include "sdram_defines.svh"

module sdram_controller_core_properties #(
    parameter int NUM_CS     = 1,
    parameter int ROW_W      = 12,
    parameter int CAS_LAT    = 3,
    parameter int T_REFI_CYC = 312,
    parameter int T_INIT_CYC = 2000
) (
    // Clock and reset
    input wire logic              mclk,
    input wire logic              rst,
    // Slave port and bridge
    input wire logic              s_waitrequest,
    input wire logic              s_readdatavalid,
    input wire logic              bridge_grant,
    // SDRAM pins
    input wire logic              sd_cke,
    input wire logic [NUM_CS-1:0] sd_cs_n,
    input wire logic              sd_ras_n,
    input wire logic              sd_cas_n,
    input wire logic              sd_we_n,
    input wire logic [ROW_W-1:0]  sd_addr,
    input wire logic [ROW_W-1:0]  sd_addr_oe,
    input wire logic              sd_dq_oe,
    input wire logic              sd_dqm_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RD_DLY  = CAS_LAT + 1;
    // Slack covers closing the open row before the refresh goes out
    localparam int REF_MAX = T_REFI_CYC + 16;

    wire logic [3:0] cmd   = {sd_cs_n[0], sd_ras_n, sd_cas_n, sd_we_n};
    wire logic       nop   = cmd[3] || cmd == `CMD_NOP;
    wire logic       is_rd = cmd == `CMD_READ;
    int unsigned     up;
    int unsigned     gap;
    logic            seen;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            up   <= 0;
            gap  <= 0;
            seen <= 1'b0;
        end
        else
        begin
            up   <= (up < T_INIT_CYC) ? up + 1 : up;
            gap  <= (cmd == `CMD_REFRESH || !seen) ? 0 : gap + 1;
            seen <= seen || !nop;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_cke_held: assert property (sd_cke)
        else $error("clock enable dropped");
    a_init_stall: assert property (up < T_INIT_CYC |-> s_waitrequest)
        else $error("transfer accepted during init");
    a_init_quiet: assert property (up < T_INIT_CYC |-> nop)
        else $error("command during init wait");
    a_init_precharge: assert property (!seen && !nop |->
        cmd == `CMD_PRECHARGE && sd_addr[`A10_BIT])
        else $error("first command not precharge all");
    a_recovery_gap: assert property
        (cmd == `CMD_REFRESH || cmd == `CMD_LOADMODE |=> nop)
        else $error("command inside recovery time");
    a_read_return: assert property (is_rd |-> ##RD_DLY s_readdatavalid)
        else $error("read data late or missing");
    a_valid_cause: assert property (s_readdatavalid |-> $past(is_rd, RD_DLY))
        else $error("read data without read command");
    a_dq_turnaround: assert property (is_rd |-> ##CAS_LAT !sd_dq_oe)
        else $error("write data driven over read data");
    a_pins_granted: assert property
        (sd_dq_oe || sd_dqm_oe || |sd_addr_oe |-> bridge_grant)
        else $error("shared pins driven without grant");
    a_refresh_due: assert property (seen |-> gap <= REF_MAX)
        else $error("refresh overdue");
endmodule

bind sdram_controller_core sdram_controller_core_properties #(
    .NUM_CS(NUM_CS), .ROW_W(ROW_W), .CAS_LAT(CAS_LAT),
    .T_REFI_CYC(T_REFI_CYC), .T_INIT_CYC(T_INIT_CYC)
) u_sdram_controller_core_properties (.mclk, .rst, .s_waitrequest, .s_readdatavalid,
    .bridge_grant, .sd_cke, .sd_cs_n, .sd_ras_n, .sd_cas_n, .sd_we_n, .sd_addr,
    .sd_addr_oe, .sd_dq_oe, .sd_dqm_oe);

// ---- dv/test_sdram_controller_core.sv ----
// Self-checking bench for the SDRAM controller core
module test_sdram_controller_core;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 0, rst = 1, s_read = 0, s_write = 0;
    logic        bridge_grant = 0, grant_on = 1;
    logic [21:0] s_address = '0;
    logic [31:0] s_writedata = '0;
    logic [3:0]  s_byteenable = '0;
    wire logic   s_waitrequest, s_readdatavalid, bridge_req, sd_cke, sd_ras_n, sd_cas_n;
    wire logic   sd_we_n, sd_dq_oe, sd_dqm_oe;
    wire logic [0:0]  sd_cs_n;
    wire logic [1:0]  sd_ba;
    wire logic [11:0] sd_addr, sd_addr_oe;
    wire logic [31:0] s_readdata, sd_dq_out, sd_dq_in;
    wire logic [3:0]  sd_dqm;
    int          fails = 0, checked = 0, ref_cnt;
    logic [31:0] shadow [logic [21:0]];
    logic [31:0] got [$];
    logic [21:0] rd_q [$];

    sdram_controller_core #(.SHARE_PINS(1'b1), .T_REFI_CYC(100), .T_INIT_CYC(50))
    u_sdram_controller_core (.mclk, .rst, .s_address, .s_read, .s_write, .s_writedata,
        .s_byteenable, .s_waitrequest, .s_readdata, .s_readdatavalid, .bridge_req,
        .bridge_grant, .sd_cke, .sd_cs_n, .sd_ras_n, .sd_cas_n, .sd_we_n, .sd_ba, .sd_addr,
        .sd_addr_oe, .sd_dq_in, .sd_dq_out, .sd_dq_oe, .sd_dqm, .sd_dqm_oe);
    sdram_chip_model u_sdram_chip_model (.mclk, .cmd({sd_cs_n[0], sd_ras_n, sd_cas_n,
        sd_we_n}), .ba(sd_ba), .addr(sd_addr), .dq_out(sd_dq_out), .dq_oe(sd_dq_oe),
        .dqm(sd_dqm), .dq_in(sd_dq_in), .ref_cnt);

    always #25 mclk = ~mclk;
    // Bench plays the bridge arbiter; grant_on lets a scenario hold the pins away
    always @(posedge mclk) bridge_grant <= bridge_req & grant_on;
    always @(negedge mclk) if (s_readdatavalid === 1'b1) got.push_back(s_readdata);

    function automatic logic [21:0] ad(input int row, input int ba, input int col);
        return {row[11:0], ba[1:0], col[7:0]};
    endfunction

    task wrap_up();
        if (fails == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    // Request stands until an edge that sees waitrequest low; release is the caller's
    task bus(input logic wr, input logic [21:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        logic [31:0] v;
        n = 0;
        s_address <= a; s_read <= !wr; s_write <= wr; s_writedata <= d; s_byteenable <= be;
        @(negedge mclk);
        while (s_waitrequest !== 1'b0 && n < 400)
        begin
            @(negedge mclk);
            n++;
        end
        chk("waitrequest", 32'h0, {31'h0, s_waitrequest});
        @(posedge mclk);
        v = shadow.exists(a) ? shadow[a] : 32'h0;
        for (int b = 0; b < 4; b++)
            if (be[b])
                v[8*b +: 8] = d[8*b +: 8];
        if (wr)
            shadow[a] = v;
        else
            rd_q.push_back(a);
    endtask

    task idle(input int c);
        s_read <= 1'b0;
        s_write <= 1'b0;
        repeat (c) @(posedge mclk);
    endtask

    task drain(input string what);
        int n;
        n = 0;
        while (got.size() < rd_q.size() && n < 2000)
        begin
            @(posedge mclk);
            n++;
        end
        chk("read count", rd_q.size(), got.size());
        while (rd_q.size() > 0 && got.size() > 0)
            chk(what, shadow[rd_q.pop_front()], got.pop_front());
        rd_q.delete();
        got.delete();
    endtask

    task t_init();
        int n;
        n = 0;
        while (s_waitrequest !== 1'b0 && n < 400)
        begin
            @(negedge mclk);
            n++;
        end
        chk("init stall", 1, n >= 50);
        chk("init refreshes", 1, ref_cnt >= 2);
        chk("cke", 1, sd_cke);
        @(posedge mclk);
    endtask

    task t_row_hit();
        for (int c = 0; c < 8; c++)
            bus(1, ad(3, 0, c), 32'h1000_0000 + c * 32'h0101, 4'hf);
        bus(1, ad(3, 0, 3), 32'haabb_ccdd, 4'h5);
        for (int c = 0; c < 8; c++)
            bus(0, ad(3, 0, c), 32'h0, 4'hf);
        idle(1);
        drain("row hit data");
    endtask

    task t_row_miss();
        int a [5] = '{ad(5, 1, 9), ad(6, 1, 9), ad(9, 2, 9), ad(5, 3, 0), ad(4095, 3, 255)};
        for (int i = 0; i < 5; i++)
            bus(1, a[i], 32'h5a00_0000 + i, 4'hf);
        for (int i = 4; i >= 0; i--)
            bus(0, a[i], 32'h0, 4'hf);
        idle(1);
        drain("row miss data");
    endtask

    task t_fill();
        int acc;
        acc = 0;
        grant_on <= 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            s_write <= 1'b1; s_address <= ad(7, 0, acc);
            s_writedata <= 32'hc0de_0000 + acc; s_byteenable <= 4'hf;
            @(negedge mclk);
            if (s_waitrequest === 1'b0)
            begin
                shadow[ad(7, 0, acc)] = 32'hc0de_0000 + acc;
                acc++;
            end
            @(posedge mclk);
        end
        chk("fifo full stall", 1, s_waitrequest);
        chk("fifo depth", 1, acc == 8);
        chk("bridge request", 1, bridge_req);
        grant_on <= 1'b1;
        idle(1);
        for (int c = 0; c < acc; c++)
            bus(0, ad(7, 0, c), 32'h0, 4'hf);
        idle(1);
        drain("fill data");
    endtask

    task t_refresh();
        int r0;
        for (int c = 0; c < 32; c++)
            bus(1, ad(2, 2, c), ~(32'h0100_0000 * c), 4'hf);
        r0 = ref_cnt;
        idle(250);
        chk("refresh issued", 1, ref_cnt - r0 >= 2);
        for (int p = 0; p < 3; p++)
            for (int c = 0; c < 32; c++)
                bus(0, ad(2, 2, c), 32'h0, 4'hf);
        idle(1);
        drain("stream data");
    endtask

    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_init();
        t_row_hit();
        t_row_miss();
        t_fill();
        t_refresh();
        wrap_up();
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        wrap_up();
    end
endmodule
